// ---- verilog/acm_pkg.sv ----
// Package of constants and types for the config word matcher
package acm_pkg;
   localparam int unsigned WORD_W = 16;
   localparam int unsigned ACK_BIT = 14;
   localparam int unsigned MATCH_RUN = 3;
   localparam int unsigned CNT_W = 2;
   localparam logic [15:0] ZERO_WORD = 16'h0000;
   localparam logic [15:0] ACK_MASK = 16'h4000;
   localparam logic [15:0] CFG_RST = 16'h0000;
   // Link timer, 10 ms at 100 MHz
   localparam int unsigned LINK_TIMER_US = 10000;
   localparam int unsigned CLK_MHZ = 100;
   localparam int unsigned LINK_TIMER_CYC = LINK_TIMER_US * CLK_MHZ;
   typedef enum logic [1:0] {
      ACM_ABIL_DET,
      ACM_ACK_DET,
      ACM_COMPLETE,
      ACM_DONE
   } acm_state_t;
endpackage

// ---- verilog/acm_run_counter.sv ----
// Counter of consecutive identical received config words
`timescale 1ns/1ps
`default_nettype none
module acm_run_counter
   import acm_pkg::*;
#(
   parameter int unsigned W = WORD_W
) (
   input wire logic core_clk, // Clock
   input wire logic rstn, // Sync reset, active low
   input wire logic clr, // Restart clear
   input wire logic word_vld, // Config word received
   input wire logic idle_vld, // Idle set received
   input wire logic [W-1:0] word, // Received word
   input wire logic [W-1:0] cmp_mask, // Bits taking part in compare
   input wire logic need_ack, // Word must carry ACK set
   output logic match, // Run reached three
   output logic [W-1:0] run_word // Word of current run
);
   logic [CNT_W-1:0] cnt_r;
   logic [W-1:0] first_r;
   logic same;
   logic ok;

   // Compare against the first word of the run, masked
   assign same = ((word & cmp_mask) == (first_r & cmp_mask));
   assign ok = !need_ack || word[ACK_BIT];
   assign match = (cnt_r == CNT_W'(MATCH_RUN));
   assign run_word = first_r;

   // Run count, saturating at three
   always_ff @(posedge core_clk) begin
      if (!rstn || clr) begin
         cnt_r <= '0;
         first_r <= CFG_RST;
      end else if (idle_vld) begin
         cnt_r <= '0;
      end else if (word_vld) begin
         if (!ok) begin
            cnt_r <= '0;
         end else if (cnt_r != '0 && same) begin
            if (cnt_r != CNT_W'(MATCH_RUN)) begin
               cnt_r <= cnt_r + 1'b1;
            end
         end else begin
            // Mismatch starts a new run at one
            cnt_r <= CNT_W'(1);
            first_r <= word;
         end
      end
   end

   AST_RESTART: assert property (@(posedge core_clk) disable iff (!rstn)
      (word_vld && !idle_vld && !clr && ok && !(cnt_r != '0 && same))
      |=> (cnt_r == CNT_W'(1)))
      else $error("mismatch did not start new run");
   AST_IDLE_CLR: assert property (@(posedge core_clk) disable iff (!rstn)
      idle_vld |=> !match)
      else $error("idle did not clear run");
endmodule // acm_run_counter
`default_nettype wire

// ---- verilog/acm_config_match.sv ----
// Receive-side config word matcher and ACK progression for autoneg
// How it works
// - Each end exchanges one 16-bit config word repeatedly, tx_word here.
// - ability_match rises after three identical words, ACK bit ignored.
// - An all-zero matched word neither sets ACK nor leaves ability detect.
// - Entering acknowledge detect, our word is sent with ACK set to one.
// - A received idle clears both match counters.
// - A second or third word unlike the first starts a new run at one; in the ack counter a word without ACK resets the run to zero.
// - Alternating words never set ACK unless they differ only in ACK.
// - Any stable non-zero word, reserved codes included, is acknowledged.
// - acknowledge_match rises after three identical words with ACK set.
// - Complete acknowledge follows only if the acked word is consistent.
// - In complete acknowledge, ACK stays set for one link_timer.
// - An inconsistent acked word restarts auto-negotiation.
`timescale 1ns/1ps
`default_nettype none
module acm_config_match
   import acm_pkg::*;
#(
   parameter int unsigned LINK_CYC = LINK_TIMER_CYC
) (
   input wire logic core_clk, // 100 MHz clock
   input wire logic rstn, // Sync reset, active low
   input wire logic an_restart, // Restart auto-negotiation
   input wire logic rx_cfg_vld, // /C/ word received, one pulse
   input wire logic rx_idle_vld, // /I/ set received, one pulse
   input wire logic [WORD_W-1:0] rx_cfg_word, // Received config word
   input wire logic [WORD_W-1:0] local_word, // Our advertised word
   output logic [WORD_W-1:0] tx_word, // Word to transmit
   output logic ability_match, // Ability run of three
   output logic acknowledge_match, // Ack run of three
   output logic an_complete, // Link timer done in complete state
   output logic restart_req, // Consistency failure pulse
   output logic [WORD_W-1:0] partner_word // Word that set ability
);
   localparam int unsigned LT_W = $clog2(LINK_CYC + 1);
   acm_state_t state_r;
   logic [LT_W-1:0] lt_cnt_r;
   logic [WORD_W-1:0] abil_word_r;
   logic [WORD_W-1:0] abil_run, ack_run;
   logic tx_ack_r;
   logic restart_r;
   logic consistent;
   logic ctr_clr;

   // Equal apart from ACK; used by the consistency check only
   function automatic logic same_but_ack(
      input logic [WORD_W-1:0] a,
      input logic [WORD_W-1:0] b
   );
      return ((a ^ b) & ~ACK_MASK) == '0;
   endfunction

   // All-zero word carries no ability and must never be acknowledged
   function automatic logic is_zero_word(input logic [WORD_W-1:0] w);
      return w == ZERO_WORD;
   endfunction

   // Clear the counters on restart so stale runs never carry over
   assign ctr_clr = an_restart || restart_r;

   acm_run_counter #(.W(WORD_W)) u_abil (
      .core_clk(core_clk),
      .rstn(rstn),
      .clr(ctr_clr),
      .word_vld(rx_cfg_vld),
      .idle_vld(rx_idle_vld),
      .word(rx_cfg_word),
      .cmp_mask(~ACK_MASK),
      .need_ack(1'b0),
      .match(ability_match),
      .run_word(abil_run)
   );

   acm_run_counter #(.W(WORD_W)) u_ack (
      .core_clk(core_clk),
      .rstn(rstn),
      .clr(ctr_clr),
      .word_vld(rx_cfg_vld),
      .idle_vld(rx_idle_vld),
      .word(rx_cfg_word),
      .cmp_mask({WORD_W{1'b1}}),
      .need_ack(1'b1),
      .match(acknowledge_match),
      .run_word(ack_run)
   );

   // Compare apart from ACK against the stored ability word
   assign consistent = same_but_ack(ack_run, abil_word_r);

   // Our word with ACK forced when acknowledging
   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         tx_word <= CFG_RST;
      end else begin
         tx_word <= tx_ack_r ? (local_word | ACK_MASK)
                             : (local_word & ~ACK_MASK);
      end
   end

   // Main progression
   always_ff @(posedge core_clk) begin
      if (!rstn || an_restart || restart_r) begin
         state_r <= ACM_ABIL_DET;
         tx_ack_r <= 1'b0;
         abil_word_r <= CFG_RST;
         lt_cnt_r <= '0;
      end else begin
         case (state_r)
            ACM_ABIL_DET: begin
               // Zero word is not an ability
               if (ability_match && !is_zero_word(abil_run)) begin
                  state_r <= ACM_ACK_DET;
                  tx_ack_r <= 1'b1;
                  abil_word_r <= abil_run;
               end
            end
            ACM_ACK_DET: begin
               if (acknowledge_match && consistent) begin
                  state_r <= ACM_COMPLETE;
                  lt_cnt_r <= '0;
               end
            end
            ACM_COMPLETE: begin
               // ACK held for the full timer
               if (lt_cnt_r == LT_W'(LINK_CYC - 1)) begin
                  state_r <= ACM_DONE;
               end else begin
                  lt_cnt_r <= lt_cnt_r + 1'b1;
               end
            end
            ACM_DONE: begin
               state_r <= ACM_DONE;
            end
            default: state_r <= ACM_ABIL_DET;
         endcase
      end
   end

   // Restart pulse on consistency failure
   always_ff @(posedge core_clk) begin
      if (!rstn || restart_r) begin
         restart_r <= 1'b0;
      end else begin
         restart_r <= (state_r == ACM_ACK_DET) && acknowledge_match &&
                      !consistent;
      end
   end

   assign restart_req = restart_r;
   assign an_complete = (state_r == ACM_DONE);
   assign partner_word = abil_word_r;

   // Stable non-zero word matched in ability detect, no restart pending
   sequence s_abil_nonzero;
      state_r == ACM_ABIL_DET && ability_match &&
      !is_zero_word(abil_run) && !an_restart && !restart_r;
   endsequence

   // Matched word is all zero, no restart pending
   sequence s_abil_zero;
      state_r == ACM_ABIL_DET && ability_match &&
      is_zero_word(abil_run) && !an_restart && !restart_r;
   endsequence

   // Acked run agrees with the ability word
   sequence s_ack_good;
      state_r == ACM_ACK_DET && acknowledge_match && consistent &&
      !an_restart && !restart_r;
   endsequence

   // Acked run disagrees; the pulse itself must not count twice
   sequence s_ack_bad;
      state_r == ACM_ACK_DET && acknowledge_match && !consistent &&
      !an_restart && !restart_r;
   endsequence

   // Failure steps: restart pulse, then back to ability detect
   sequence s_restart_steps;
      restart_r ##1 state_r == ACM_ABIL_DET;
   endsequence

   // Ability detect guards
   AST_ZERO_NO_ACK: assert property (@(posedge core_clk) disable iff (!rstn)
      s_abil_zero |=> !tx_ack_r && state_r == ACM_ABIL_DET)
      else $error("ACK set on zero word");
   AST_ACK_TX: assert property (@(posedge core_clk) disable iff (!rstn)
      (tx_ack_r && $past(tx_ack_r)) |-> tx_word[ACK_BIT])
      else $error("ACK bit not transmitted");
   AST_ABIL_GO: assert property (@(posedge core_clk) disable iff (!rstn)
      s_abil_nonzero |=> state_r == ACM_ACK_DET && tx_ack_r)
      else $error("stable word not acknowledged");
   AST_ABIL_WORD: assert property (@(posedge core_clk) disable iff (!rstn)
      s_abil_nonzero |=> partner_word == $past(abil_run))
      else $error("matched word not captured");
   // ACK must stay off on the line while no ability was accepted
   AST_NO_ACK_IN_DET: assert property (@(posedge core_clk) disable iff (!rstn)
      (state_r == ACM_ABIL_DET && $past(state_r == ACM_ABIL_DET))
      |-> !tx_word[ACK_BIT])
      else $error("ACK sent without accepted ability");

   // Acknowledge detect guards
   AST_COMPLETE_GO: assert property (@(posedge core_clk) disable iff (!rstn)
      s_ack_good |=> state_r == ACM_COMPLETE)
      else $error("consistent ack did not complete");
   AST_CONSIST: assert property (@(posedge core_clk) disable iff (!rstn)
      s_ack_bad |=> s_restart_steps)
      else $error("inconsistent ack not restarted");
   AST_NO_COMPLETE: assert property (@(posedge core_clk) disable iff (!rstn)
      (state_r == ACM_ACK_DET && !consistent) |=> state_r != ACM_COMPLETE)
      else $error("completed on inconsistent word");
   AST_RESTART_CLR: assert property (@(posedge core_clk) disable iff (!rstn)
      restart_r |=> (state_r == ACM_ABIL_DET && !ability_match &&
                     !acknowledge_match))
      else $error("restart left stale state");

   // Complete acknowledge guards
   AST_HOLD_ACK: assert property (@(posedge core_clk) disable iff (!rstn)
      (state_r == ACM_COMPLETE) |-> tx_ack_r && tx_word[ACK_BIT])
      else $error("ACK dropped in complete");
   // Done only after the timer has run its whole span
   AST_TIMER_FULL: assert property (@(posedge core_clk) disable iff (!rstn)
      $rose(an_complete) |-> $past(lt_cnt_r) == LT_W'(LINK_CYC - 1))
      else $error("complete before link timer ran out");
   AST_DONE_STAY: assert property (@(posedge core_clk) disable iff (!rstn)
      (an_complete && !an_restart) |=> an_complete)
      else $error("complete dropped without restart");
endmodule // acm_config_match
`default_nettype wire

// ---- bench/acm_lp_model.sv ----
// Link partner model sending config words and idles
`timescale 1ns/1ps
`default_nettype none
module acm_lp_model (
   input wire logic core_clk, // Clock
   input wire logic [15:0] tx_word, // Word from our side
   output logic cfg_vld, // Config word strobe
   output logic idle_vld, // Idle strobe
   output logic [15:0] cfg_word, // Received config word
   output logic ack_seen // Three ACKed words seen
);
   logic [1:0] ack_cnt;
   initial begin
      cfg_vld = 1'b0;
      idle_vld = 1'b0;
      cfg_word = 16'h0000;
   end
   // Partner may only complete after three ACKed words
   always @(posedge core_clk) begin
      if (!tx_word[14]) ack_cnt <= 2'd0;
      else if (ack_cnt != 2'd3) ack_cnt <= ack_cnt + 2'd1;
   end
   assign ack_seen = (ack_cnt == 2'd3);
   // One word per cycle; after the last word the line shows the inverse
   task automatic send(input logic [15:0] w, input int n);
      repeat (n) begin
         @(negedge core_clk);
         cfg_vld = 1'b1;
         cfg_word = w;
      end
      @(negedge core_clk);
      cfg_vld = 1'b0;
      cfg_word = ~w;
   endtask
   task automatic idle(input int n);
      repeat (n) begin
         @(negedge core_clk);
         idle_vld = 1'b1;
      end
      @(negedge core_clk);
      idle_vld = 1'b0;
   endtask
endmodule // acm_lp_model
`default_nettype wire

// ---- bench/tb.sv ----
// Testbench for the config word matcher
`timescale 1ns/1ps
`default_nettype none
module tb;
   import acm_pkg::*;
   localparam int unsigned LC = 20;
   logic core_clk, rstn, an_restart, cfg_vld, idle_vld, ack_seen;
   logic ability_match, acknowledge_match, an_complete, restart_req;
   logic rst_seen;
   logic [15:0] cfg_word, tx_word, partner_word, local_word, txa, txn;
   int err_total, num_checks;
   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end
   acm_config_match #(.LINK_CYC(LC)) dut_u (.core_clk(core_clk),
      .rstn(rstn), .an_restart(an_restart), .rx_cfg_vld(cfg_vld),
      .rx_idle_vld(idle_vld), .rx_cfg_word(cfg_word),
      .local_word(local_word), .tx_word(tx_word),
      .ability_match(ability_match), .acknowledge_match(acknowledge_match),
      .an_complete(an_complete), .restart_req(restart_req),
      .partner_word(partner_word));
   acm_lp_model lp_u (.core_clk(core_clk), .tx_word(tx_word),
      .cfg_vld(cfg_vld), .idle_vld(idle_vld), .cfg_word(cfg_word),
      .ack_seen(ack_seen));
   // Restart pulse is one cycle wide, so latch it
   // Cleared by each restart here, so one process owns the flag
   always @(posedge core_clk) begin
      if (an_restart === 1'b1) rst_seen <= 1'b0;
      else if (restart_req === 1'b1) rst_seen <= 1'b1;
   end
   task automatic chk(input string nm, input logic [15:0] got, exp);
      num_checks++;
      if (got !== exp) begin
         err_total++;
         $display("MISMATCH %s exp %h got %h", nm, exp, got);
      end
   endtask
   task automatic wt(input int n);
      repeat (n) @(negedge core_clk);
   endtask
   task automatic restart();
      @(negedge core_clk);
      an_restart = 1'b1;
      @(negedge core_clk);
      an_restart = 1'b0;
   endtask
   // Zero word matches but must not be acknowledged
   task automatic t_zero();
      restart();
      lp_u.send(16'h0000, 4);
      chk("abil_zero", ability_match, 1'b1);
      wt(3);
      chk("tx_zero", tx_word, txn);
   endtask
   // Idle and mismatches restart the run
   task automatic t_count();
      restart();
      lp_u.send(16'h01A0, 2);
      lp_u.idle(1);
      lp_u.send(16'h01A0, 2);
      chk("abil_idle", ability_match, 1'b0);
      lp_u.send(16'h0FFF, 2);
      chk("abil_diff", ability_match, 1'b0);
      lp_u.send(16'h0FFF, 1);
      chk("abil_new", ability_match, 1'b1);
      wt(2);
      chk("tx_ack", tx_word, txa);
      chk("pword", partner_word, 16'h0FFF);
   endtask
   // Alternating words, then ones differing only in ACK
   task automatic t_alt();
      restart();
      repeat (4) begin
         lp_u.send(16'h01E0, 1);
         lp_u.send(16'h01A0, 1);
      end
      chk("abil_alt", ability_match, 1'b0);
      wt(3);
      chk("tx_alt", tx_word, txn);
      lp_u.send(16'h41A0, 1);
      lp_u.send(16'h01A0, 1);
      lp_u.send(16'h41A0, 1);
      chk("abil_ackonly", ability_match, 1'b1);
   endtask
   // Acknowledge run, then link timer to completion
   task automatic t_ack();
      restart();
      lp_u.send(16'h01A0, 3);
      lp_u.send(16'h41A0, 2);
      lp_u.send(16'h01A0, 1);
      lp_u.send(16'h41A0, 2);
      chk("ackm_broken", acknowledge_match, 1'b0);
      lp_u.send(16'h41A0, 1);
      chk("ackm", acknowledge_match, 1'b1);
      wt(3);
      chk("cmpl_early", an_complete, 1'b0);
      chk("tx_hold", tx_word, txa);
      chk("lp_ack", ack_seen, 1'b1);
      wt(LC + 5);
      chk("cmpl", an_complete, 1'b1);
      chk("no_rst", rst_seen, 1'b0);
   endtask
   // Acked word inconsistent with the ability word
   task automatic t_incons();
      restart();
      lp_u.send(16'h01A0, 3);
      lp_u.send(16'h4120, 3);
      wt(3);
      chk("rst_req", rst_seen, 1'b1);
      chk("abil_clr", ability_match, 1'b0);
      wt(LC + 5);
      chk("cmpl_bad", an_complete, 1'b0);
   endtask
   task automatic complete_run();
      $display("checks %0d errors %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   initial begin
      rstn = 1'b0;
      an_restart = 1'b0;
      local_word = 16'h0C20;
      txa = 16'h0C20 | ACK_MASK;
      txn = 16'h0C20 & ~ACK_MASK;
      err_total = 0;
      num_checks = 0;
      wt(6);
      chk("tx_rst", tx_word, 16'h0000);
      rstn = 1'b1;
      t_zero();
      t_count();
      t_alt();
      t_ack();
      t_incons();
      complete_run();
   end
   // Whole run is well under 2000 cycles
   initial begin
      #20000;
      err_total++;
      complete_run();
   end
endmodule // tb
`default_nettype wire
